// File: core/cpld_fabric.sv
// Top of the programmable logic fabric: four blocks, switch matrix, pin cells, config port.
//
// Functional notes
// - four blocks, matrix fed by 70 pins
// - four clock pins double as inputs
// - block has array, allocator, 16 macrocells, pins
// - matrix gives each block 26 inputs
// - blocks return macrocell and pin feedback
// - 64 logic terms plus 6 special terms
// - pins in two banks of eight
// - init terms set whole block asynchronously
// - at most 12 terms per macrocell
// - macrocell n uses clusters n-1..n+1
// - registered or combinatorial, polarity, feedback kept
// - register acts as D or T
// - each flip-flop picks one clock pin
// - capture only on rising clock edge
// - driver on, off, or term controlled
// - term enable chosen within own bank
// - buried macrocell frees pin for input
//
// Our own choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module cpld_fabric (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [10:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  input wire logic [cpld_pkg::NPIN-1:0] io_in_i,
  output logic [cpld_pkg::NPIN-1:0] io_out_o,
  output logic [cpld_pkg::NPIN-1:0] io_oe_o,
  input wire logic [cpld_pkg::NDED-1:0] ded_in_i,
  input wire logic [cpld_pkg::NCLK-1:0] clk_pin_i
);
  // ----------------------------------------------------------------
  // Configuration store and fabric nets
  // ----------------------------------------------------------------
  cpld_pkg::pt_mask_t [cpld_pkg::NPT-1:0] term_ff [cpld_pkg::NBLK];
  cpld_pkg::pt_mask_t [cpld_pkg::NPT-1:0] nxt_term [cpld_pkg::NBLK];
  logic [7:0] sel_ff [cpld_pkg::NBLK][cpld_pkg::NIN];
  logic [7:0] nxt_sel [cpld_pkg::NBLK][cpld_pkg::NIN];
  cpld_pkg::mc_cfg_t [cpld_pkg::NMC-1:0] cfg_ff [cpld_pkg::NBLK];
  cpld_pkg::mc_cfg_t [cpld_pkg::NMC-1:0] nxt_cfg [cpld_pkg::NBLK];

  cpld_pkg::bus_state_t state_ff;
  cpld_pkg::bus_state_t nxt_state;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [31:0] rd;
  logic hit_term;
  logic hit_sel;
  logic hit_cfg;
  int d_blk;
  int d_idx;
  int d_half;

  logic [cpld_pkg::NCLK-1:0] clk_prev_ff;
  logic [cpld_pkg::NCLK-1:0] clk_edge;
  logic [cpld_pkg::NSRC-1:0] src;
  logic [cpld_pkg::NPIN-1:0] mc_all;
  logic [cpld_pkg::NIN-1:0] blk_in [cpld_pkg::NBLK];
  logic [cpld_pkg::NMC-1:0] sum [cpld_pkg::NBLK];
  logic [cpld_pkg::NMC-1:0] mc [cpld_pkg::NBLK];
  logic [cpld_pkg::NSPEC-1:0] spec [cpld_pkg::NBLK];

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        old[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return old;
  endfunction : be_merge

  function automatic logic src_pick(input logic [7:0] s,
                                    input logic [cpld_pkg::NSRC-1:0] v);
    return (int'(s) < cpld_pkg::NSRC) ? v[s] : 1'b0;
  endfunction : src_pick

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    int off;
    off = int'(address_i);
    hit_term = 1'b0;
    hit_sel = 1'b0;
    hit_cfg = 1'b0;
    d_blk = 0;
    d_idx = 0;
    d_half = 0;
    if (address_i < cpld_pkg::SEL_BASE) begin
      d_blk = off / cpld_pkg::TERM_STRIDE;
      d_idx = (off % cpld_pkg::TERM_STRIDE) / 2;
      d_half = off % 2;
      hit_term = d_idx < cpld_pkg::NPT;
    end else if (address_i < cpld_pkg::CFG_BASE) begin
      off = off - int'(cpld_pkg::SEL_BASE);
      d_blk = off / cpld_pkg::SEL_STRIDE;
      d_idx = off % cpld_pkg::SEL_STRIDE;
      hit_sel = d_idx < cpld_pkg::NIN;
    end else if (address_i < cpld_pkg::STAT_MC_LO) begin
      off = off - int'(cpld_pkg::CFG_BASE);
      d_blk = off / cpld_pkg::CFG_STRIDE;
      d_idx = off % cpld_pkg::CFG_STRIDE;
      hit_cfg = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped words read as zero; status words show live fabric state.
  always_comb begin
    rd = 32'h0000_0000;
    if (hit_term) begin
      rd[cpld_pkg::NIN-1:0] = term_ff[d_blk][d_idx][d_half];
    end else if (hit_sel) begin
      rd[7:0] = sel_ff[d_blk][d_idx];
    end else if (hit_cfg) begin
      rd[cpld_pkg::CFG_W-1:0] = cfg_ff[d_blk][d_idx];
    end else if (address_i == cpld_pkg::STAT_MC_LO) begin
      rd = mc_all[31:0];
    end else if (address_i == cpld_pkg::STAT_MC_HI) begin
      rd = mc_all[63:32];
    end else if (address_i == cpld_pkg::STAT_PIN_LO) begin
      rd = io_in_i[31:0];
    end else if (address_i == cpld_pkg::STAT_PIN_HI) begin
      rd = io_in_i[63:32];
    end
  end

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  // Writes commit only on the answering edge, so a held request never writes twice.
  always_comb begin
    logic [31:0] w;
    w = 32'h0000_0000;
    nxt_state = state_ff;
    nxt_rdata = rdata_ff;
    nxt_term = term_ff;
    nxt_sel = sel_ff;
    nxt_cfg = cfg_ff;
    case (state_ff)
      cpld_pkg::BUS_IDLE: begin
        if (read_i || write_i) begin
          nxt_state = cpld_pkg::BUS_ANS;
          nxt_rdata = read_i ? rd : rdata_ff;
        end
      end
      cpld_pkg::BUS_ANS: begin
        nxt_state = cpld_pkg::BUS_IDLE;
        if (write_i && hit_term) begin
          w = be_merge(32'(term_ff[d_blk][d_idx][d_half]), writedata_i, byteenable_i);
          nxt_term[d_blk][d_idx][d_half] = w[cpld_pkg::NIN-1:0];
        end else if (write_i && hit_sel) begin
          w = be_merge(32'(sel_ff[d_blk][d_idx]), writedata_i, byteenable_i);
          nxt_sel[d_blk][d_idx] = w[7:0];
        end else if (write_i && hit_cfg) begin
          w = be_merge(32'(cfg_ff[d_blk][d_idx]), writedata_i, byteenable_i);
          nxt_cfg[d_blk][d_idx] = w[cpld_pkg::CFG_W-1:0];
        end
      end
      default: begin
        nxt_state = cpld_pkg::BUS_IDLE;
      end
    endcase
  end

  assign waitrequest_o = (read_i || write_i) && (state_ff != cpld_pkg::BUS_ANS);
  assign readdata_o = rdata_ff;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= cpld_pkg::BUS_IDLE;
      rdata_ff <= 32'h0000_0000;
      clk_prev_ff <= '0;
      for (int b = 0; b < cpld_pkg::NBLK; b++) begin
        cfg_ff[b] <= {cpld_pkg::NMC{cpld_pkg::CFG_RST}};
        for (int t = 0; t < cpld_pkg::NPT; t++) begin
          term_ff[b][t] <= {cpld_pkg::MASK_RST, cpld_pkg::MASK_RST};
        end
        for (int i = 0; i < cpld_pkg::NIN; i++) begin
          sel_ff[b][i] <= cpld_pkg::SEL_RST;
        end
      end
    end else begin
      state_ff <= nxt_state;
      rdata_ff <= nxt_rdata;
      clk_prev_ff <= clk_pin_i;
      term_ff <= nxt_term;
      sel_ff <= nxt_sel;
      cfg_ff <= nxt_cfg;
    end
  end

  // ----------------------------------------------------------------
  // Clock pins and switch matrix
  // ----------------------------------------------------------------
  assign clk_edge = clk_pin_i & ~clk_prev_ff;

  // Pin feedback is the pin level itself, so an undriven pin acts as an input.
  assign src = {mc_all, clk_pin_i, ded_in_i, io_in_i};

  always_comb begin
    for (int b = 0; b < cpld_pkg::NBLK; b++) begin
      for (int i = 0; i < cpld_pkg::NIN; i++) begin
        blk_in[b][i] = src_pick(sel_ff[b][i], src);
      end
      mc_all[b*cpld_pkg::NMC +: cpld_pkg::NMC] = mc[b];
    end
  end

  // ----------------------------------------------------------------
  // Logic blocks
  // ----------------------------------------------------------------
  // Combinatorial feedback can form a loop through the matrix if software so routes it.
  for (genvar gb = 0; gb < cpld_pkg::NBLK; gb++) begin : g_blk
    term_array u_terms (
      .blk_in_i(blk_in[gb]),
      .mask_i(term_ff[gb]),
      .cfg_i(cfg_ff[gb]),
      .sum_o(sum[gb]),
      .spec_o(spec[gb])
    );
    macro_bank u_cells (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .clk_edge_i(clk_edge),
      .sum_i(sum[gb]),
      .cfg_i(cfg_ff[gb]),
      .rst_pt_i(spec[gb][cpld_pkg::SP_RST]),
      .pre_pt_i(spec[gb][cpld_pkg::SP_PRE]),
      .mc_o(mc[gb])
    );
  end

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  // Pin outputs follow the macrocell directly so combinatorial paths stay unregistered.
  always_comb begin
    int p;
    int k;
    cpld_pkg::mc_cfg_t c;
    p = 0;
    k = 0;
    c = cpld_pkg::CFG_RST;
    for (int b = 0; b < cpld_pkg::NBLK; b++) begin
      for (int m = 0; m < cpld_pkg::NMC; m++) begin
        p = b * cpld_pkg::NMC + m;
        c = cfg_ff[b][m];
        k = (m / cpld_pkg::BANK_W) * cpld_pkg::OE_PER_BANK + int'(c.oe_sel);
        io_out_o[p] = mc[b][m];
        case (c.oe_mode)
          cpld_pkg::OE_OFF: io_oe_o[p] = 1'b0;
          cpld_pkg::OE_ON: io_oe_o[p] = 1'b1;
          cpld_pkg::OE_PT: io_oe_o[p] = spec[b][k];
          default: io_oe_o[p] = 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  bus_answer_a: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("slave did not answer after one wait cycle");
  cfg_write_a: assert property (state_ff == cpld_pkg::BUS_ANS && write_i
      && address_i == cpld_pkg::CFG_BASE && byteenable_i == 4'hF
      |=> {21'h0, cfg_ff[0][0]} == ($past(writedata_i) & 32'h0000_07FF))
    else $error("macrocell configuration write was lost");
  oe_force_a: assert property (cfg_ff[0][1].oe_mode == cpld_pkg::OE_ON
      |-> io_oe_o[1] ##1 (cfg_ff[0][1].oe_mode != cpld_pkg::OE_OFF || !io_oe_o[1]))
    else $error("fixed output enable not honoured");
  oe_bank_a: assert property (cfg_ff[0][8].oe_mode == cpld_pkg::OE_PT
      |-> io_oe_o[8] == spec[0][2 + int'(cfg_ff[0][8].oe_sel)])
    else $error("pin enable taken from the wrong bank term");
  clk_input_a: assert property (sel_ff[0][2] == 8'h45 |-> blk_in[0][2] == clk_pin_i[3])
    else $error("clock pin not routed as a logic input");
  buried_a: assert property (!io_oe_o[5] && sel_ff[0][3] == 8'h05
      |-> blk_in[0][3] == io_in_i[5] && blk_in[0][3] == src[5])
    else $error("undriven pin not usable as input");

  bus_write_c: cover property (write_i && !waitrequest_o);
  oe_term_c: cover property (cfg_ff[0][0].oe_mode == cpld_pkg::OE_PT && io_oe_o[0]);
  clk_edge_c: cover property (|clk_edge);
endmodule : cpld_fabric

// File: core/cpld_pkg.sv
// Shared constants, register map and carrier types of the logic-block fabric.
package cpld_pkg;
  // ----------------------------------------------------------------
  // Fabric dimensions
  // ----------------------------------------------------------------
  localparam int NBLK = 4;
  localparam int NPIN = 64;
  localparam int NDED = 2;
  localparam int NCLK = 4;
  localparam int NMC = 16;
  localparam int NIN = 26;
  localparam int NLT = 64;
  localparam int NPT = 70;
  localparam int NSPEC = 6;
  localparam int NCLU = 16;
  localparam int CLU_W = 4;
  localparam int BANK_W = 8;
  localparam int OE_PER_BANK = 2;
  // ----------------------------------------------------------------
  // Switch-matrix source positions and special term slots
  // ----------------------------------------------------------------
  localparam int NSRC = 134;
  localparam int SRC_PIN = 0;
  localparam int SRC_DED = 64;
  localparam int SRC_CLK = 66;
  localparam int SRC_MC = 70;
  localparam int SP_RST = 4;
  localparam int SP_PRE = 5;
  // ----------------------------------------------------------------
  // Register map (word addresses)
  // ----------------------------------------------------------------
  localparam int AW = 11;
  localparam int SEL_W = 8;
  localparam int CFG_W = 11;
  localparam logic [10:0] SEL_BASE = 11'h400;
  localparam logic [10:0] CFG_BASE = 11'h480;
  localparam logic [10:0] STAT_MC_LO = 11'h4C0;
  localparam logic [10:0] STAT_MC_HI = 11'h4C1;
  localparam logic [10:0] STAT_PIN_LO = 11'h4C2;
  localparam logic [10:0] STAT_PIN_HI = 11'h4C3;
  localparam int TERM_STRIDE = 256;
  localparam int SEL_STRIDE = 32;
  localparam int CFG_STRIDE = 16;
  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [25:0] MASK_RST = 26'h3FFFFFF;
  localparam logic [7:0] SEL_RST = 8'hFF;
  localparam logic [1:0] OE_OFF = 2'h0;
  localparam logic [1:0] OE_ON = 2'h1;
  localparam logic [1:0] OE_PT = 2'h2;

  typedef enum {BUS_IDLE, BUS_ANS} bus_state_t;

  // Index 0 is the true-input mask, index 1 the complement mask.
  typedef logic [1:0][NIN-1:0] pt_mask_t;

  typedef struct packed {
    logic [2:0] clus_en;
    logic reg_en;
    logic invert;
    logic ttype;
    logic [1:0] clk_sel;
    logic [1:0] oe_mode;
    logic oe_sel;
  } mc_cfg_t;

  localparam mc_cfg_t CFG_RST = 11'h000;
endpackage : cpld_pkg

// File: core/term_array.sv
// Product-term array and logic allocator of one logic block.
`timescale 1ns/1ps
module term_array (
  input wire logic [cpld_pkg::NIN-1:0] blk_in_i,
  input wire cpld_pkg::pt_mask_t [cpld_pkg::NPT-1:0] mask_i,
  input wire cpld_pkg::mc_cfg_t [cpld_pkg::NMC-1:0] cfg_i,
  output logic [cpld_pkg::NMC-1:0] sum_o,
  output logic [cpld_pkg::NSPEC-1:0] spec_o
);
  logic [cpld_pkg::NPT-1:0] pt;

  // A term with both masks set for one input is constant zero; that is the erased state.
  function automatic logic pterm(input logic [cpld_pkg::NIN-1:0] v,
                                 input cpld_pkg::pt_mask_t m);
    return &((v | ~m[0]) & (~v | ~m[1]));
  endfunction : pterm

  always_comb begin
    for (int t = 0; t < cpld_pkg::NPT; t++) begin
      pt[t] = pterm(blk_in_i, mask_i[t]);
    end
  end

  assign spec_o = pt[cpld_pkg::NPT-1:cpld_pkg::NLT];

  // ----------------------------------------------------------------
  // Allocator
  // ----------------------------------------------------------------
  // Clusters may be granted to two neighbours at once; the sum simply ORs them.
  always_comb begin
    int c;
    c = 0;
    for (int n = 0; n < cpld_pkg::NMC; n++) begin
      sum_o[n] = 1'b0;
      for (int k = 0; k < 3; k++) begin
        c = n - 1 + k;
        if (c >= 0 && c < cpld_pkg::NCLU && cfg_i[n].clus_en[k]) begin
          sum_o[n] = sum_o[n] | (|pt[c*cpld_pkg::CLU_W +: cpld_pkg::CLU_W]);
        end
      end
    end
  end
endmodule : term_array

// File: core/macro_bank.sv
// Sixteen macrocells of one logic block with their flip-flops.
`timescale 1ns/1ps
module macro_bank (
  input wire logic mclk_i,
  input wire logic resetn_i,
  input wire logic [cpld_pkg::NCLK-1:0] clk_edge_i,
  input wire logic [cpld_pkg::NMC-1:0] sum_i,
  input wire cpld_pkg::mc_cfg_t [cpld_pkg::NMC-1:0] cfg_i,
  input wire logic rst_pt_i,
  input wire logic pre_pt_i,
  output logic [cpld_pkg::NMC-1:0] mc_o
);
  logic [cpld_pkg::NMC-1:0] q_ff;
  logic [cpld_pkg::NMC-1:0] nxt_q;
  logic [cpld_pkg::NMC-1:0] q_eff;

  always_comb begin
    for (int m = 0; m < cpld_pkg::NMC; m++) begin
      nxt_q[m] = q_ff[m];
      if (rst_pt_i) begin
        nxt_q[m] = 1'b0;
      end else if (pre_pt_i) begin
        nxt_q[m] = 1'b1;
      end else if (cfg_i[m].reg_en && clk_edge_i[cfg_i[m].clk_sel]) begin
        nxt_q[m] = cfg_i[m].ttype ? (q_ff[m] ^ sum_i[m]) : sum_i[m];
      end
    end
  end

  // The init terms act on the output at once, not only at the next edge.
  always_comb begin
    q_eff = rst_pt_i ? '0 : (pre_pt_i ? '1 : q_ff);
    for (int m = 0; m < cpld_pkg::NMC; m++) begin
      mc_o[m] = (cfg_i[m].reg_en ? q_eff[m] : sum_i[m]) ^ cfg_i[m].invert;
    end
  end

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  rst_first_a: assert property (rst_pt_i && pre_pt_i |=> q_ff == 16'h0000)
    else $error("reset term did not win over preset term");
  preset_all_a: assert property (pre_pt_i && !rst_pt_i |=> q_ff == 16'hFFFF)
    else $error("preset term did not set every flip-flop");
  hold_idle_a: assert property (!(|clk_edge_i) && !rst_pt_i && !pre_pt_i |=> $stable(q_ff))
    else $error("flip-flop changed without a clock edge");
  t_toggle_a: assert property (cfg_i[2].reg_en && cfg_i[2].ttype && sum_i[2]
      && clk_edge_i[cfg_i[2].clk_sel] && !rst_pt_i && !pre_pt_i
      |=> q_ff[2] != $past(q_ff[2]))
    else $error("T flip-flop did not toggle");
  d_load_a: assert property (cfg_i[2].reg_en && !cfg_i[2].ttype
      && clk_edge_i[cfg_i[2].clk_sel] && !rst_pt_i && !pre_pt_i
      |=> q_ff[2] == $past(sum_i[2]))
    else $error("D flip-flop did not load its sum");
  clk_pick_a: assert property (!clk_edge_i[cfg_i[2].clk_sel] && !rst_pt_i && !pre_pt_i
      |=> q_ff[2] == $past(q_ff[2]))
    else $error("flip-flop followed an unselected clock");

  toggle_seen_c: cover property (cfg_i[2].ttype && clk_edge_i[cfg_i[2].clk_sel] ##1
      $changed(q_ff[2]));
endmodule : macro_bank

// File: sim/board_model.sv
// Board logic on the far side of the pins: drives or releases each pin and resolves the wire.
`timescale 1ns/1ps
module board_model (
  input wire logic mclk_i,
  input wire logic [63:0] io_out_i,
  input wire logic [63:0] io_oe_i,
  input wire logic [63:0] drv_en_i,
  input wire logic [63:0] drv_val_i,
  output logic [63:0] io_in_o
);
  logic [63:0] last_ff = 64'h0;

  // --------------------------------------------------------------
  // Wire resolution
  // --------------------------------------------------------------
  // A floating pin shows the inverse of its last level, so a stale value can never pass.
  always_comb begin
    for (int p = 0; p < 64; p++) begin
      io_in_o[p] = io_oe_i[p] ? io_out_i[p] : (drv_en_i[p] ? drv_val_i[p] : ~last_ff[p]);
    end
  end

  always_ff @(posedge mclk_i) begin
    last_ff <= io_in_o;
  end
endmodule : board_model

// File: sim/cpld_fabric_tb.sv
// Self-checking bench of the logic-block fabric with a board model on its pins.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp=%h got=%h", nm, e, g); end end
module cpld_fabric_tb;
  typedef struct packed {
    logic [3:0] mc;
    logic [10:0] cfg;
    logic [1:0] ded;
    logic out;
    logic oe;
  } row_t;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [10:0] address_i = 11'h000;
  logic read_i = 1'b0;
  logic write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0] byteenable_i = 4'hF;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic [63:0] io_in_i;
  logic [63:0] io_out_o;
  logic [63:0] io_oe_o;
  logic [63:0] drv_en = 64'h0;
  logic [63:0] drv_val = 64'h0;
  logic [1:0] ded_in_i = 2'h0;
  logic [3:0] clk_pin_i = 4'h0;
  logic [31:0] q;
  int n_fail = 0;
  int compares = 0;
  row_t rows [14] = '{
    '{4'h0, 11'h202, 2'h1, 1'b1, 1'b1},
    '{4'h0, 11'h202, 2'h2, 1'b0, 1'b1},
    '{4'h0, 11'h602, 2'h2, 1'b1, 1'b1},
    '{4'h0, 11'h642, 2'h0, 1'b1, 1'b1},
    '{4'h0, 11'h102, 2'h3, 1'b0, 1'b1},
    '{4'h1, 11'h102, 2'h1, 1'b1, 1'b1},
    '{4'h1, 11'h202, 2'h2, 1'b1, 1'b1},
    '{4'h0, 11'h200, 2'h1, 1'b1, 1'b0},
    '{4'h0, 11'h206, 2'h1, 1'b1, 1'b0},
    '{4'h0, 11'h204, 2'h2, 1'b0, 1'b1},
    '{4'h0, 11'h205, 2'h2, 1'b0, 1'b0},
    '{4'h0, 11'h204, 2'h1, 1'b1, 1'b0},
    '{4'h8, 11'h004, 2'h2, 1'b0, 1'b0},
    '{4'h8, 11'h004, 2'h1, 1'b0, 1'b1}
  };

  cpld_fabric i_cpld_fabric (.mclk_i(mclk_i), .resetn_i(resetn_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .io_in_i(io_in_i), .io_out_o(io_out_o), .io_oe_o(io_oe_o), .ded_in_i(ded_in_i),
    .clk_pin_i(clk_pin_i));
  board_model i_board_model (.mclk_i(mclk_i), .io_out_i(io_out_o), .io_oe_i(io_oe_o),
    .drv_en_i(drv_en), .drv_val_i(drv_val), .io_in_o(io_in_i));

  always #5 mclk_i = ~mclk_i;

  // --------------------------------------------------------------
  // Bus and pin tasks
  // --------------------------------------------------------------
  task automatic bus(input logic wr, input logic [10:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    read_i <= ~wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    if (n >= 20) n_fail++;
    q = readdata_o;
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask : bus

  task automatic setterm(input int t, input logic [25:0] m);
    bus(1'b1, 11'(t * 2), {6'h0, m});
    bus(1'b1, 11'(t * 2 + 1), 32'h0);
  endtask : setterm

  task automatic pins(input logic [1:0] d, input logic [3:0] c, input int w);
    @(posedge mclk_i);
    ded_in_i <= d;
    clk_pin_i <= c;
    repeat (w) @(posedge mclk_i);
  endtask : pins

  task automatic tally_and_finish;
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // The whole sequence needs well under a thousand cycles; ten thousand means a hang.
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk_i);
    resetn_i <= 1'b1;
    @(posedge mclk_i);
    `CHK("oe_rst", 64'h0, io_oe_o)
    bus(1'b1, 11'h400, 32'h40);
    bus(1'b1, 11'h401, 32'h41);
    bus(1'b1, 11'h402, 32'h45);
    bus(1'b1, 11'h403, 32'h05);
    bus(1'b1, 11'h404, 32'h48);
    setterm(0, 26'h1);
    setterm(4, 26'h2);
    setterm(64, 26'h2);
    setterm(66, 26'h1);
    foreach (rows[i]) begin
      bus(1'b1, 11'h480 + {7'h0, rows[i].mc}, {21'h0, rows[i].cfg});
      pins(rows[i].ded, 4'h0, 1);
      `CHK("row_out", rows[i].out, io_out_o[rows[i].mc])
      `CHK("row_oe", rows[i].oe, io_oe_o[rows[i].mc])
    end
    bus(1'b1, 11'h482, 32'h28A);
    bus(1'b1, 11'h486, 32'h202);
    bus(1'b1, 11'h484, 32'h202);
    setterm(8, 26'h1);
    setterm(16, 26'h8);
    setterm(24, 26'h10);
    pins(2'h1, 4'h0, 3);
    `CHK("hold", 1'b0, io_out_o[2])
    pins(2'h1, 4'h2, 3);
    `CHK("d_cap", 1'b1, io_out_o[2])
    `CHK("feedback", 1'b1, io_out_o[6])
    pins(2'h0, 4'h0, 3);
    `CHK("fall", 1'b1, io_out_o[2])
    pins(2'h0, 4'h1, 3);
    `CHK("clk_sel", 1'b1, io_out_o[2])
    bus(1'b1, 11'h482, 32'h2AA);
    for (int k = 0; k < 3; k++) begin
      pins({1'b0, k < 2}, 4'h0, 1);
      pins({1'b0, k < 2}, 4'h2, 3);
      `CHK("toggle", 1'(k != 0), io_out_o[2])
    end
    bus(1'b0, 11'h4C0, 32'h0);
    `CHK("stat_mc", 1'b1, q[2])
    setterm(68, 26'h2);
    setterm(69, 26'h4);
    pins(2'h2, 4'h0, 2);
    `CHK("areset", 1'b0, io_out_o[2])
    pins(2'h0, 4'h0, 2);
    `CHK("ainit", 1'b0, io_out_o[2])
    pins(2'h0, 4'h8, 2);
    `CHK("apreset", 1'b1, io_out_o[2])
    pins(2'h2, 4'h8, 2);
    `CHK("rst_wins", 1'b0, io_out_o[2])
    pins(2'h0, 4'h0, 1);
    drv_en[5] <= 1'b1;
    drv_val[5] <= 1'b1;
    @(posedge mclk_i);
    `CHK("pin_in", 1'b1, io_out_o[4])
    `CHK("buried_oe", 1'b0, io_oe_o[5])
    bus(1'b0, 11'h4C2, 32'h0);
    `CHK("stat_pin", 1'b1, q[5])
    drv_val[5] <= 1'b0;
    @(posedge mclk_i);
    `CHK("pin_in0", 1'b0, io_out_o[4])
    byteenable_i <= 4'h0;
    bus(1'b1, 11'h400, 32'hFF);
    byteenable_i <= 4'hF;
    bus(1'b0, 11'h400, 32'h0);
    `CHK("sel_be", 32'h40, q)
    bus(1'b1, 11'h41A, 32'h5);
    bus(1'b0, 11'h41A, 32'h0);
    `CHK("unmapped", 32'h0, q)
    bus(1'b1, 11'h460, 32'h41);
    bus(1'b1, 11'h378, 32'h0);
    bus(1'b1, 11'h379, 32'h1);
    bus(1'b1, 11'h4BF, 32'h202);
    pins(2'h2, 4'h0, 1);
    `CHK("compl_lo", 1'b0, io_out_o[63])
    pins(2'h0, 4'h0, 1);
    `CHK("compl_hi", 1'b1, io_out_o[63])
    bus(1'b0, 11'h4C1, 32'h0);
    `CHK("stat_mc_hi", 1'b1, q[31])
    bus(1'b1, 11'h4BF, 32'h402);
    pins(2'h0, 4'h0, 1);
    `CHK("clip_hi", 1'b0, io_out_o[63])
    resetn_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    `CHK("oe_mid_rst", 64'h0, io_oe_o)
    `CHK("out_mid_rst", 64'h0, io_out_o)
    resetn_i <= 1'b1;
    bus(1'b0, 11'h480, 32'h0);
    `CHK("cfg_rst", 32'h0, q)
    bus(1'b0, 11'h000, 32'h0);
    `CHK("term_rst", 32'h3FFFFFF, q)
    tally_and_finish();
  end
endmodule : cpld_fabric_tb
